// ---- rdlc_pkg.sv ----
// Shared constants of the redriver equalization and link control registers
package rdlc_pkg;
  // Register offsets
  localparam logic [7:0] DOWN_EQ_OFFSET = 8'h20;
  localparam logic [7:0] UP_EQ_OFFSET = 8'h21;
  localparam logic [7:0] LINK_CTRL_OFFSET = 8'h22;
  // Reset values
  localparam logic [7:0] DOWN_EQ_RESET = 8'h00;
  localparam logic [3:0] UP_EQ_RESET = 4'h0;
  localparam logic [6:0] LINK_CTRL_RESET = 7'h04;
  // Field positions in the link control register
  localparam int COMPLIANCE_ACTIVE_BIT = 7;
  localparam int APPLY_A_BIT = 6;
  localparam int EXIT_DEBOUNCE_BIT = 5;
  localparam int DETECT_OFF_BIT = 4;
  localparam int DETECT_PERIOD_LSB = 2;
  localparam int COMPLIANCE_SEL_LSB = 0;
  // Compliance mode encodings
  localparam logic [1:0] COMPLIANCE_FSM = 2'h0;
  localparam logic [1:0] COMPLIANCE_DOWN = 2'h1;
  localparam logic [1:0] COMPLIANCE_UP = 2'h2;
  localparam logic [1:0] COMPLIANCE_OFF = 2'h3;
  // Four-level strap codes
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_RES = 2'h1;
  localparam logic [1:0] STRAP_FLOAT = 2'h2;
  localparam logic [1:0] STRAP_HIGH = 2'h3;
  // Slave address: upper bits fixed, low bits from the two address straps
  localparam logic [2:0] SLAVE_ADDR_TOP = 3'h1;
  // Timing
  localparam int CLK_FREQ_KHZ = 40000;
  localparam int EXIT_DEBOUNCE_US = 200;
  localparam int EXIT_DEBOUNCE_CYCLES = EXIT_DEBOUNCE_US * CLK_FREQ_KHZ / 1000;
  localparam int DETECT_8_MS = 8;
  localparam int DETECT_12_MS = 12;
  localparam int DETECT_48_MS = 48;
  localparam int DETECT_96_MS = 96;
  localparam int DETECT_8_CYCLES = DETECT_8_MS * CLK_FREQ_KHZ;
  localparam int DETECT_12_CYCLES = DETECT_12_MS * CLK_FREQ_KHZ;
  localparam int DETECT_48_CYCLES = DETECT_48_MS * CLK_FREQ_KHZ;
  localparam int DETECT_96_CYCLES = DETECT_96_MS * CLK_FREQ_KHZ;
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

  typedef enum logic [4:0] {
    RDLC_IDLE = 5'b00001,
    RDLC_RXBYTE = 5'b00010,
    RDLC_ACK = 5'b00100,
    RDLC_TXBYTE = 5'b01000,
    RDLC_RXACK = 5'b10000
  } rdlc_state_t;

  // Strap level to equalization code; upstream spans a wider range
  function automatic logic [3:0] rdlc_eq_from_strap(input logic [1:0] level, input logic up);
    case (level)
      STRAP_LOW: rdlc_eq_from_strap = 4'h0;
      STRAP_RES: rdlc_eq_from_strap = up ? 4'h4 : 4'h3;
      STRAP_FLOAT: rdlc_eq_from_strap = up ? 4'h8 : 4'h6;
      default: rdlc_eq_from_strap = up ? 4'hb : 4'h9;
    endcase
  endfunction : rdlc_eq_from_strap
endpackage : rdlc_pkg

// ---- rdlc_i2c_slave.sv ----
// Byte-wide two-wire slave with a register pointer
`timescale 1ns/1ps
module rdlc_i2c_slave
  import rdlc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOe,
  // Register side
  input wire logic [6:0] devAddr,
  input wire logic [7:0] rdData,
  output logic [7:0] regPtr,
  output logic wrEn,
  output logic [7:0] wrData
);
  logic [1:0] sclSync_reg, sdaSync_reg;
  logic sclPrev_reg, sdaPrev_reg;
  rdlc_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bitCnt_reg;
  logic [1:0] phase_reg;
  logic readMode_reg, masterAck_reg;

  wire sclNow = sclSync_reg[1];
  wire sdaNow = sdaSync_reg[1];
  wire startSeen = sclNow && sclPrev_reg && sdaPrev_reg && !sdaNow;
  wire stopSeen = sclNow && sclPrev_reg && !sdaPrev_reg && sdaNow;
  wire sclRise = sclNow && !sclPrev_reg;
  wire sclFall = !sclNow && sclPrev_reg;
  wire byteDone = sclFall && (bitCnt_reg == 4'h8);
  wire addrHit = (shift_reg[7:1] == devAddr);

  // Two flops before any logic looks at the pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclSync_reg <= 2'h3;
      sdaSync_reg <= 2'h3;
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      sclSync_reg <= {sclSync_reg[0], sclIn};
      sdaSync_reg <= {sdaSync_reg[0], sdaIn};
      sclPrev_reg <= sclNow;
      sdaPrev_reg <= sdaNow;
    end
  end

  // Phase 0 address, 1 register index, 2 data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= RDLC_IDLE;
      shift_reg <= 8'h00;
      bitCnt_reg <= 4'h0;
      phase_reg <= 2'h0;
      readMode_reg <= 1'b0;
      masterAck_reg <= 1'b0;
      regPtr <= 8'h00;
      wrEn <= 1'b0;
      wrData <= 8'h00;
      sdaOe <= 1'b0;
    end else begin
      wrEn <= 1'b0;
      if (startSeen) begin
        state_reg <= RDLC_RXBYTE;
        bitCnt_reg <= 4'h0;
        phase_reg <= 2'h0;
        sdaOe <= 1'b0;
      end else if (stopSeen) begin
        state_reg <= RDLC_IDLE;
        sdaOe <= 1'b0;
      end else begin
        case (state_reg)
          RDLC_RXBYTE: begin
            if (sclRise) begin
              shift_reg <= {shift_reg[6:0], sdaNow};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (byteDone) begin
              if (phase_reg == 2'h0 && !addrHit) begin
                state_reg <= RDLC_IDLE;
              end else begin
                state_reg <= RDLC_ACK;
                sdaOe <= 1'b1;
                if (phase_reg == 2'h0) begin
                  readMode_reg <= shift_reg[0];
                end else if (phase_reg == 2'h1) begin
                  regPtr <= shift_reg;
                end else begin
                  wrEn <= 1'b1;
                  wrData <= shift_reg;
                end
              end
            end
          end
          RDLC_ACK: begin
            if (sclFall) begin
              bitCnt_reg <= 4'h0;
              if (phase_reg == 2'h2 && !readMode_reg) begin
                regPtr <= regPtr + 8'h01;
              end
              if (phase_reg == 2'h0 && readMode_reg) begin
                state_reg <= RDLC_TXBYTE;
                shift_reg <= rdData;
                sdaOe <= !rdData[7];
              end else begin
                state_reg <= RDLC_RXBYTE;
                sdaOe <= 1'b0;
                phase_reg <= (phase_reg == 2'h0) ? 2'h1 : 2'h2;
              end
            end
          end
          RDLC_TXBYTE: begin
            if (sclRise) begin
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (byteDone) begin
              state_reg <= RDLC_RXACK;
              sdaOe <= 1'b0;
              regPtr <= regPtr + 8'h01;
            end else if (sclFall) begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sdaOe <= !shift_reg[6];
            end
          end
          RDLC_RXACK: begin
            if (sclRise) begin
              masterAck_reg <= !sdaNow;
            end else if (sclFall) begin
              bitCnt_reg <= 4'h0;
              // A not-acknowledge ends the read until the next start
              state_reg <= masterAck_reg ? RDLC_TXBYTE : RDLC_IDLE;
              shift_reg <= rdData;
              sdaOe <= masterAck_reg && !rdData[7];
            end
          end
          default: state_reg <= RDLC_IDLE;
        endcase
      end
    end
  end
endmodule : rdlc_i2c_slave

// ---- rdlc_regs.sv ----
// Equalization and link control register bank behind the two-wire port
//
// Contract
// - Register downstream_rx_eq_select bits 7:4 pick the second downstream receiver equalization, 0-9 dB.
// - Register downstream_rx_eq_select bits 3:0 pick the first downstream receiver equalization, 0-9 dB.
// - With override, software-written downstream fields drive the receivers.
// - Upstream field follows its straps without override, software value with it.
// - Register link_power_compliance_ctrl bit 7 reads one while in compliance mode.
// - Bit 6 zero forces zero equalization during LFPS; one keeps selected values.
// - Bit 5 one requires 200 us of LFPS before leaving U2 or U3.
// - Bit 4 one suppresses receiver detection while in U2 or U3.
// - Bits 3:2 set detection interval: 8, 12, 48 or 96 ms.
// - Bits 1:0: state machine, force downstream, force upstream, or disable compliance.
// - Reset reads 0x00 at downstream_rx_eq_select and upstream_rx_eq_select, 0x04 at link_power_compliance_ctrl.
// - Floating address straps give slave address 0x12; other levels give others.
// - Each receiver equalization is set independently through registers.
// - Override input selects strap-derived or programmed equalization.
// - Writes: address with write bit, register index, data; each byte acknowledged.
`timescale 1ns/1ps
module rdlc_regs
  import rdlc_pkg::*;
#(
  parameter int EXIT_DEBOUNCE_LEN = EXIT_DEBOUNCE_CYCLES,
  parameter int DETECT_8_LEN = DETECT_8_CYCLES,
  parameter int DETECT_12_LEN = DETECT_12_CYCLES,
  parameter int DETECT_48_LEN = DETECT_48_CYCLES,
  parameter int DETECT_96_LEN = DETECT_96_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Two-wire bus; the pin is driven low while sdaOe is high
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Four-level straps
  input wire logic [1:0] downstreamEqStraps,
  input wire logic [1:0] upstreamEqStraps,
  input wire logic [1:0] addressStrapHigh,
  input wire logic [1:0] addressStrapLow,
  // Link state from on-chip logic
  input wire logic eqSourceOverride,
  input wire logic inLowPower,
  input wire logic complianceActiveIn,
  // Analog LFPS detector
  input wire logic lfpsDetect,
  // Equalization to the receivers
  output logic [3:0] firstDownstreamEq,
  output logic [3:0] secondDownstreamEq,
  output logic [3:0] upstreamEq,
  // Link control
  output logic lowPowerExitReq,
  output logic rxDetectStart,
  output logic forceDownstreamCompliance,
  output logic forceUpstreamCompliance,
  output logic complianceDisable
);
  logic [7:0] strapSync1_reg, strapSync2_reg, strapHeld_reg;
  logic [1:0] settleCnt_reg;
  logic strapValid_reg;
  logic [1:0] lfpsSync_reg;
  logic [7:0] downEq_reg, downEq_next;
  logic [3:0] upEq_reg, upEq_next;
  logic [6:0] linkCtrl_reg;
  logic complianceActive_reg;
  logic [12:0] debCnt_reg;
  logic [21:0] detCnt_reg;
  logic [7:0] regPtr, wrData, rdData;
  logic wrEn;

  // Straps pass two flops, then are held once settled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strapSync1_reg <= 8'h00;
      strapSync2_reg <= 8'h00;
      strapHeld_reg <= 8'h00;
      settleCnt_reg <= 2'h0;
      strapValid_reg <= 1'b0;
    end else begin
      strapSync1_reg <= {downstreamEqStraps, upstreamEqStraps, addressStrapHigh, addressStrapLow};
      strapSync2_reg <= strapSync1_reg;
      if (!strapValid_reg) begin
        settleCnt_reg <= settleCnt_reg + 2'h1;
        if (settleCnt_reg == STRAP_SETTLE_CYCLES) begin
          strapHeld_reg <= strapSync2_reg;
          strapValid_reg <= 1'b1;
        end
      end
    end
  end

  wire [3:0] strapDownEq = rdlc_eq_from_strap(strapHeld_reg[7:6], 1'b0);
  wire [3:0] strapUpEq = rdlc_eq_from_strap(strapHeld_reg[5:4], 1'b1);
  // Floating on both straps lands on 0x12
  wire [6:0] devAddr = {SLAVE_ADDR_TOP, strapHeld_reg[3:2] ^ STRAP_FLOAT, strapHeld_reg[1:0]};

  rdlc_i2c_slave u_slave (
    .clk(clk),
    .rst_n(rst_n),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOe(sdaOe),
    .devAddr(devAddr),
    .rdData(rdData),
    .regPtr(regPtr),
    .wrEn(wrEn),
    .wrData(wrData)
  );

  wire wrDown = wrEn && (regPtr == DOWN_EQ_OFFSET);
  wire wrUp = wrEn && (regPtr == UP_EQ_OFFSET);
  wire wrCtrl = wrEn && (regPtr == LINK_CTRL_OFFSET);
  wire mirrorStraps = !eqSourceOverride && strapValid_reg;

  // Without override, software writes are overrun by the strap values
  assign downEq_next = mirrorStraps ? {strapDownEq, strapDownEq} :
                       (eqSourceOverride && wrDown) ? wrData : downEq_reg;
  assign upEq_next = mirrorStraps ? strapUpEq :
                     (eqSourceOverride && wrUp) ? wrData[3:0] : upEq_reg;

  assign rdData = (regPtr == DOWN_EQ_OFFSET) ? downEq_reg :
                  (regPtr == UP_EQ_OFFSET) ? {4'h0, upEq_reg} :
                  (regPtr == LINK_CTRL_OFFSET) ? {complianceActive_reg, linkCtrl_reg} :
                  8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      downEq_reg <= DOWN_EQ_RESET;
      upEq_reg <= UP_EQ_RESET;
      linkCtrl_reg <= LINK_CTRL_RESET;
      complianceActive_reg <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      downEq_reg <= downEq_next;
      upEq_reg <= upEq_next;
      if (wrCtrl) begin
        linkCtrl_reg <= wrData[6:0];
      end
      complianceActive_reg <= complianceActiveIn;
      sdaOut <= 1'b0;
    end
  end

  // LFPS detector is analog, so it is synchronised
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfpsSync_reg <= 2'h0;
    end else begin
      lfpsSync_reg <= {lfpsSync_reg[0], lfpsDetect};
    end
  end

  wire lfpsNow = lfpsSync_reg[1];
  wire zeroEq = lfpsNow && !linkCtrl_reg[APPLY_A_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      firstDownstreamEq <= 4'h0;
      secondDownstreamEq <= 4'h0;
      upstreamEq <= 4'h0;
    end else begin
      firstDownstreamEq <= zeroEq ? 4'h0 : downEq_reg[3:0];
      secondDownstreamEq <= zeroEq ? 4'h0 : downEq_reg[7:4];
      upstreamEq <= zeroEq ? 4'h0 : upEq_reg;
    end
  end

  // Exit request holds while LFPS persists; the link state machine leaves low power
  wire debounceOn = linkCtrl_reg[EXIT_DEBOUNCE_BIT];
  wire debounceDone = (debCnt_reg >= 13'(EXIT_DEBOUNCE_LEN - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      debCnt_reg <= 13'h0000;
      lowPowerExitReq <= 1'b0;
    end else begin
      lowPowerExitReq <= inLowPower && lfpsNow && (!debounceOn || debounceDone);
      if (!inLowPower || !lfpsNow) begin
        debCnt_reg <= 13'h0000;
      end else if (!debounceDone) begin
        debCnt_reg <= debCnt_reg + 13'h0001;
      end
    end
  end

  // Detection period select
  wire [1:0] periodSel = linkCtrl_reg[DETECT_PERIOD_LSB +: 2];
  wire [21:0] detectLimit = (periodSel == 2'h0) ? 22'(DETECT_8_LEN - 1) :
                            (periodSel == 2'h1) ? 22'(DETECT_12_LEN - 1) :
                            (periodSel == 2'h2) ? 22'(DETECT_48_LEN - 1) :
                            22'(DETECT_96_LEN - 1);
  wire detectEnabled = !(inLowPower && linkCtrl_reg[DETECT_OFF_BIT]);
  wire detectDue = detectEnabled && (detCnt_reg >= detectLimit);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      detCnt_reg <= 22'h000000;
      rxDetectStart <= 1'b0;
    end else begin
      rxDetectStart <= detectDue;
      // Control writes restart the count, so a shorter period never finds it overrun
      if (!detectEnabled || detectDue || wrCtrl) begin
        detCnt_reg <= 22'h000000;
      end else begin
        detCnt_reg <= detCnt_reg + 22'h000001;
      end
    end
  end

  wire [1:0] complianceSel = linkCtrl_reg[COMPLIANCE_SEL_LSB +: 2];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      forceDownstreamCompliance <= 1'b0;
      forceUpstreamCompliance <= 1'b0;
      complianceDisable <= 1'b0;
    end else begin
      forceDownstreamCompliance <= (complianceSel == COMPLIANCE_DOWN);
      forceUpstreamCompliance <= (complianceSel == COMPLIANCE_UP);
      complianceDisable <= (complianceSel == COMPLIANCE_OFF);
    end
  end

  a_down_mirror: assert property (@(posedge clk) disable iff (!rst_n)
    mirrorStraps |=> downEq_reg == {$past(strapDownEq), $past(strapDownEq)})
    else $error("downstream field not following straps");
  a_down_override: assert property (@(posedge clk) disable iff (!rst_n)
    (eqSourceOverride && wrDown) |=> ##1 secondDownstreamEq == ($past(zeroEq) ? 4'h0 : $past(wrData, 2) >> 4))
    else $error("written downstream value not applied");
  a_up_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    (regPtr == UP_EQ_OFFSET) |-> rdData[7:4] == 4'h0)
    else $error("upstream reserved bits not zero");
  a_up_source: assert property (@(posedge clk) disable iff (!rst_n)
    (eqSourceOverride && !wrUp) |=> $stable(upEq_reg))
    else $error("upstream field changed under override");
  a_status_bit: assert property (@(posedge clk) disable iff (!rst_n)
    (regPtr == LINK_CTRL_OFFSET) ##1 (regPtr == LINK_CTRL_OFFSET) |-> rdData[7] == $past(complianceActiveIn))
    else $error("compliance status bit wrong");
  a_lfps_zero: assert property (@(posedge clk) disable iff (!rst_n)
    zeroEq |=> firstDownstreamEq == 4'h0 && upstreamEq == 4'h0)
    else $error("equalization not zero during LFPS");
  a_exit_debounce: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(lowPowerExitReq) && $past(debounceOn)) |-> $past(debCnt_reg) == 13'(EXIT_DEBOUNCE_LEN - 1))
    else $error("low power exit before debounce time");
  a_detect_off: assert property (@(posedge clk) disable iff (!rst_n)
    (inLowPower && linkCtrl_reg[DETECT_OFF_BIT]) |=> !rxDetectStart)
    else $error("detection in low power while suppressed");
  a_detect_period: assert property (@(posedge clk) disable iff (!rst_n)
    rxDetectStart |-> $past(detCnt_reg) == $past(detectLimit))
    else $error("detection interval wrong");
  a_compliance_map: assert property (@(posedge clk) disable iff (!rst_n)
    (complianceSel == COMPLIANCE_FSM) |=> !forceDownstreamCompliance && !forceUpstreamCompliance
      && !complianceDisable)
    else $error("compliance forced in state machine mode");
endmodule : rdlc_regs

// ---- rdlc_i2c_master.sv ----
// Two-wire bus master model standing in for the controller
`timescale 1ns/1ps
module rdlc_i2c_master (
  // Clock
  input wire logic clk,
  // Bus pins; data line pulled low while sdaOe is high
  input wire logic sdaIn,
  output logic sclOut,
  output logic sdaOe
);
  // Half bit time in clocks; raise it for a slow controller
  int half = 12;
  initial begin
    sclOut = 1'b1;
    sdaOe = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold
  // Data moves two clocks after the clock line falls, never while it is high
  task automatic putBit(input logic b);
    sdaOe <= ~b;
    hold(half);
    sclOut <= 1'b1;
    hold(half);
    sclOut <= 1'b0;
    hold(2);
  endtask : putBit
  task automatic getBit(output logic b);
    sdaOe <= 1'b0;
    hold(half);
    sclOut <= 1'b1;
    hold(half / 2);
    b = sdaIn;
    hold(half - half / 2);
    sclOut <= 1'b0;
    hold(2);
  endtask : getBit
  task automatic start;
    sdaOe <= 1'b0;
    hold(half);
    sclOut <= 1'b1;
    hold(half);
    sdaOe <= 1'b1;
    hold(half);
    sclOut <= 1'b0;
    hold(2);
  endtask : start
  task automatic stop;
    sdaOe <= 1'b1;
    hold(half);
    sclOut <= 1'b1;
    hold(half);
    sdaOe <= 1'b0;
    hold(half);
  endtask : stop
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) putBit(d[i]);
    getBit(b);
    ack = (b === 1'b0);
  endtask : sendByte
  task automatic getByte(input logic more, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) getBit(d[i]);
    putBit(~more);
  endtask : getByte
  // Address with write bit, index, one data byte, then stop
  task automatic writeReg(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d,
                          output logic ok);
    logic a0, a1, a2;
    start();
    sendByte({a, 1'b0}, a0);
    sendByte(idx, a1);
    sendByte(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : writeReg
  // Index set by a write, repeated start, one byte read then refused
  task automatic readReg(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] d,
                         output logic ok);
    logic a0, a1, a2;
    start();
    sendByte({a, 1'b0}, a0);
    sendByte(idx, a1);
    start();
    sendByte({a, 1'b1}, a2);
    getByte(1'b0, d);
    stop();
    ok = a0 & a1 & a2;
  endtask : readReg
endmodule : rdlc_i2c_master

// ---- test_redriver_eq_link_control_regs.sv ----
// Self-checking bench for the equalization and link control registers
`timescale 1ns/1ps
module test_redriver_eq_link_control_regs;
  import rdlc_pkg::*;
  localparam int DEB = 20;
  localparam int DLEN [4] = '{40, 60, 80, 100};
  localparam int DCODE [4] = '{0, 3, 6, 9};
  localparam int UCODE [4] = '{0, 4, 8, 11};
  logic clk, rst_n, dutOe, mOe, scl, ovr, lowPwr, cmIn, lfps;
  logic [1:0] dStrap, uStrap, aHigh, aLow;
  logic [3:0] eq1, eq2, eqUp;
  logic exitReq, rxDet, fDown, fUp, cmOff, ok, sdaLvl;
  logic [6:0] addr;
  logic [7:0] rd;
  int failCount = 0, testsRun = 0, seed = 32'h1d7e, mDown, mUp, mCtrl, n;
  // Open drain with pull-up
  wire sda = ~(dutOe | mOe);
  rdlc_regs #(.EXIT_DEBOUNCE_LEN(DEB), .DETECT_8_LEN(40), .DETECT_12_LEN(60),
    .DETECT_48_LEN(80), .DETECT_96_LEN(100)) u_dut (.clk(clk), .rst_n(rst_n), .sclIn(scl),
    .sdaIn(sda), .sdaOut(sdaLvl), .sdaOe(dutOe), .downstreamEqStraps(dStrap),
    .upstreamEqStraps(uStrap), .addressStrapHigh(aHigh), .addressStrapLow(aLow),
    .eqSourceOverride(ovr), .inLowPower(lowPwr), .complianceActiveIn(cmIn),
    .lfpsDetect(lfps), .firstDownstreamEq(eq1), .secondDownstreamEq(eq2), .upstreamEq(eqUp),
    .lowPowerExitReq(exitReq), .rxDetectStart(rxDet), .forceDownstreamCompliance(fDown),
    .forceUpstreamCompliance(fUp), .complianceDisable(cmOff));
  rdlc_i2c_master u_master (.clk(clk), .sdaIn(sda), .sclOut(scl), .sdaOe(mOe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic hold(input int k);
    repeat (k) @(posedge clk);
  endtask : hold
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  // Model follows the write; discarded fields stay as they were
  task automatic regWr(input logic [7:0] idx, input logic [7:0] d);
    u_master.writeReg(addr, idx, d, ok);
    check({sdaLvl, ok}, 2'b01);
    if (idx == 8'h20 && ovr) mDown = d;
    if (idx == 8'h21 && ovr) mUp = d & 8'h0f;
    if (idx == 8'h22) mCtrl = d & 8'h7f;
  endtask : regWr
  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
    u_master.readReg(addr, idx, rd, ok);
    check({ok, rd}, {1'b1, exp});
  endtask : rdChk
  task automatic outChk(input logic zero);
    check({eq2, eq1, eqUp}, zero ? 12'h000 : {mDown[7:0], mUp[3:0]});
  endtask : outChk
  // Straps stay put through release so the capture sees them
  task automatic doReset(input logic [1:0] d, input logic [1:0] u, input logic [1:0] h,
                         input logic [1:0] l);
    rst_n <= 1'b0;
    dStrap <= d;
    uStrap <= u;
    aHigh <= h;
    aLow <= l;
    hold(4);
    check({exitReq, rxDet, eq1, eq2, eqUp}, 14'h0);
    rst_n <= 1'b1;
    hold(12);
    addr = {3'b001, h ^ 2'b10, l};
    mDown = ovr ? 0 : DCODE[d] * 17;
    mUp = ovr ? 0 : UCODE[u];
    mCtrl = 8'h04;
  endtask : doReset
  task automatic gap(output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rxDet !== 1'b1 && k < 400);
  endtask : gap
  initial begin
    rst_n = 1'b0;
    {ovr, lowPwr, cmIn, lfps} = 4'h8;
    {dStrap, uStrap, aHigh, aLow} = 8'haa;
    doReset(2'h2, 2'h1, 2'h2, 2'h2);
    check(addr, 7'h12);
    rdChk(8'h20, 8'h00);
    rdChk(8'h21, 8'h00);
    rdChk(8'h22, 8'h04);
    u_master.writeReg(7'h13, 8'h20, 8'h55, ok);
    check(ok, 1'b0);
    for (int i = 0; i < 3; i++) begin
      regWr(8'h20, 8'($random(seed)));
      regWr(8'h21, 8'($random(seed)));
      rdChk(8'h20, mDown[7:0]);
      rdChk(8'h21, mUp[7:0]);
      outChk(1'b0);
    end
    rdChk(8'h05, 8'h00);
    for (int c = 0; c < 4; c++) begin
      cmIn <= c[0];
      regWr(8'h22, {1'b0, 5'($random(seed)), c[1:0]});
      rdChk(8'h22, {c[0], mCtrl[6:0]});
      check({fDown, fUp, cmOff}, {c == 1, c == 2, c == 3});
    end
    regWr(8'h22, 8'h00);
    lfps <= 1'b1;
    hold(6);
    outChk(1'b1);
    regWr(8'h22, 8'h40);
    outChk(1'b0);
    lfps <= 1'b0;
    lowPwr <= 1'b1;
    hold(6);
    check(exitReq, 1'b0);
    lfps <= 1'b1;
    hold(6);
    check(exitReq, 1'b1);
    lfps <= 1'b0;
    regWr(8'h22, 8'h20);
    lfps <= 1'b1;
    // Two sync edges plus the full debounce count before the request rises
    hold(DEB + 1);
    check(exitReq, 1'b0);
    hold(2);
    check(exitReq, 1'b1);
    lfps <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      regWr(8'h22, 8'(k << 2));
      gap(n);
      gap(n);
      check(n, DLEN[k]);
    end
    regWr(8'h22, 8'h10);
    gap(n);
    gap(n);
    check(n, 400);
    ovr <= 1'b0;
    hold(4);
    mDown = DCODE[2] * 17;
    mUp = UCODE[1];
    outChk(1'b0);
    regWr(8'h20, 8'ha5);
    rdChk(8'h20, mDown[7:0]);
    dStrap <= 2'h3;
    uStrap <= 2'h3;
    hold(10);
    rdChk(8'h21, mUp[7:0]);
    u_master.half = 20;
    doReset(2'($random(seed)), 2'($random(seed)), 2'($random(seed)), 2'($random(seed)));
    rdChk(8'h20, mDown[7:0]);
    rdChk(8'h21, mUp[7:0]);
    outChk(1'b0);
    tally_and_finish();
  end
  // Hang guard sized well above the planned sequence
  initial begin
    hold(95000);
    failCount++;
    tally_and_finish();
  end
endmodule : test_redriver_eq_link_control_regs
